// [cce_card_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cce_card_model (
   input  wire logic  cardClk,
   input  wire logic  cardRst,
   input  wire logic  ioOut,
   input  wire logic  ioOe,
   output logic       ioIn,
   output logic [7:0] progBits
);
   logic [15:0] mem = 16'hA5C3;
   logic [3:0]  pos = 4'h0;
   // bit pointer restarts on reset, steps per pulse; records driven-low bits
   always @(posedge cardClk or posedge cardRst) begin
      if (cardRst) begin
         pos <= 4'h0;
      end else begin
         pos <= pos + 4'h1;
         progBits <= {~(ioOe & ~ioOut), progBits[7:1]};
      end
   end
   assign ioIn = ioOe ? ioOut : mem[pos];
endmodule
`default_nettype wire

// [cce_card_phy.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cce_map.svh"
module cce_card_phy
   import cce_pkg::*;
(
   input  wire logic    clock,
   input  wire logic    rstn,
   input  wire logic    start,
   input  wire cce_op_t op,
   input  wire logic    ioIn,
   output logic         done,
   output logic         bitIn,
   output logic         cardClk,
   output logic         cardRst,
   output logic         cardAux,
   output logic         ioOut,
   output logic         ioOe
);
   cce_phase_t  ph;
   cce_op_t     cur;
   logic [15:0] timer;
   logic [7:0]  left;
   wire         tmo     = (timer == 16'h0000);
   wire  [15:0] highLen = cur.longHigh ? `CCE_PROG_CYC - 16'h0001 : `CCE_HALF_CYC - 16'h0001;
   wire         fin     = tmo && (((ph == PH_SETUP) && (cur.pulses == 8'h00)) || ((ph == PH_LOW) && (left == 8'h00)));
   // ----------------------------------------
   // setup half, sample, then pulses
   // ----------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ph      <= PH_IDLE;
         cur     <= '0;
         timer   <= 16'h0000;
         left    <= 8'h00;
         done    <= 1'b0;
         bitIn   <= 1'b0;
         cardClk <= 1'b0;
         cardRst <= 1'b0;
         cardAux <= 1'b0;
         ioOut   <= 1'b0;
         ioOe    <= 1'b0;
      end else begin
         done <= 1'b0;
         if (ph == PH_SETUP && tmo) begin
            bitIn <= ioIn;
         end
         if (ph != PH_IDLE && !tmo) begin
            timer <= timer - 16'h0001;
         end
         if (fin) begin
            ph      <= PH_IDLE;
            done    <= 1'b1;
            cardRst <= 1'b0;
            cardAux <= 1'b0;
            ioOe    <= 1'b0;
            ioOut   <= 1'b0;
         end else begin
            case (ph)
               PH_IDLE: if (start) begin
                  cur     <= op;
                  ph      <= PH_SETUP;
                  timer   <= `CCE_HALF_CYC - 16'h0001;
                  cardRst <= op.rst;
                  cardAux <= op.aux;
                  ioOe    <= op.ioOe;
                  ioOut   <= op.ioOut;
               end
               PH_SETUP: if (tmo) begin
                  cardClk <= 1'b1;
                  left    <= cur.pulses - 8'h01;
                  timer   <= highLen;
                  ph      <= PH_HIGH;
               end
               PH_HIGH: if (tmo) begin
                  cardClk <= 1'b0;
                  timer   <= `CCE_HALF_CYC - 16'h0001;
                  ph      <= PH_LOW;
               end
               PH_LOW: if (tmo) begin
                  cardClk <= 1'b1;
                  left    <= left - 8'h01;
                  timer   <= highLen;
                  ph      <= PH_HIGH;
               end
               default: ph <= PH_IDLE;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// [cce_engine.sv]
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "cce_map.svh"
module cce_engine
   import cce_pkg::*;
#(
   parameter int POWER_OFF_CYC = `CCE_PWROFF_CYC
) (
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [31:0] dat_i,
   input  wire logic [3:0]  sel_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   output logic             cardPower,
   output logic             cardClk,
   output logic             cardRst,
   output logic             cardAux,
   input  wire logic        cardIoIn,
   output logic             cardIoOut,
   output logic             cardIoOe
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [31:0] hdr;
   logic [7:0]  lenReg;
   logic [31:0] dat0;
   logic [31:0] dat1;
   logic [1:0]  cfg;
   logic [15:0] sw;
   logic        busy;
   logic        dataValid;
   logic [7:0]  rdata;
   logic [15:0] res;
   logic        resHeld;
   cce_state_t  st;
   cce_state_t  afterSeek;
   cce_state_t  retState;
   logic        waitOp;
   logic        start;
   logic [5:0]  bitCnt;
   logic [7:0]  byteCnt;
   logic [7:0]  seekAddr;
   logic [31:0] pwrCnt;
   logic        ioSync;
   logic        phyDone;
   logic        phyBit;
   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   wire        wbAcc   = cyc_i && stb_i && !ack_o;
   wire        wr      = wbAcc && we_i;
   wire        rd      = wbAcc && !we_i;
   wire [7:0]  adr     = {adr_i[7:2], 2'b00};
   wire [31:0] mask    = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
   wire        wrCmd   = wr && !busy;
   wire        goReq   = wr && (adr == `CCE_ADR_CTRL) && sel_i[0] && dat_i[0];
   wire        popReq  = rd && (adr == `CCE_ADR_RDATA);
   wire [31:0] status  = {sw, 13'h0000, resHeld, dataValid, busy};
   wire [31:0] rdMux   = (adr == `CCE_ADR_STATUS) ? status :
                         (adr == `CCE_ADR_HDR)    ? hdr :
                         (adr == `CCE_ADR_LEN)    ? {24'h000000, lenReg} :
                         (adr == `CCE_ADR_DATA0)  ? dat0 :
                         (adr == `CCE_ADR_DATA1)  ? dat1 :
                         (adr == `CCE_ADR_RDATA)  ? {24'h000000, rdata} :
                         (adr == `CCE_ADR_CFG)    ? {30'h00000000, cfg} : 32'h00000000;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
      end else begin
         ack_o <= wbAcc;
         dat_o <= rd ? rdMux : 32'h00000000;
      end
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         hdr    <= 32'h00000000;
         lenReg <= 8'h00;
         dat0   <= 32'h00000000;
         dat1   <= 32'h00000000;
         cfg    <= `CCE_CFG_RST;
      end else if (wrCmd) begin
         if (adr == `CCE_ADR_HDR) hdr <= (hdr & ~mask) | (dat_i & mask);
         if (adr == `CCE_ADR_LEN && sel_i[0]) lenReg <= dat_i[7:0];
         if (adr == `CCE_ADR_DATA0) dat0 <= (dat0 & ~mask) | (dat_i & mask);
         if (adr == `CCE_ADR_DATA1) dat1 <= (dat1 & ~mask) | (dat_i & mask);
         if (adr == `CCE_ADR_CFG && sel_i[0]) cfg <= dat_i[1:0];
      end
   end
   // ----------------------------------------
   // command fields
   // ----------------------------------------
   wire [7:0]  cla      = hdr[31:24];
   wire [7:0]  ins      = hdr[23:16];
   wire [7:0]  p1       = hdr[15:8];
   wire [7:0]  p2       = hdr[7:0];
   wire [63:0] dataVec  = {dat1, dat0};
   wire [7:0]  b0       = dat0[7:0];
   wire [7:0]  b1       = dat0[15:8];
   wire        backupOk = cfg[0];
   wire        chainOk  = cfg[1];
   wire        isSel    = (ins == `CCE_INS_SELECT);
   wire        isRd     = (ins == `CCE_INS_READ);
   wire        isWr     = (ins == `CCE_INS_WRITE);
   wire        isCode   = (ins == `CCE_INS_CODE);
   wire        isAuth   = (ins == `CCE_INS_AUTH);
   wire        isFetch  = (ins == `CCE_INS_FETCH);
   wire        p12Bad   = (p1 != 8'h00) || (p2 != 8'h00);
   wire        modeBad  = (b0 > `CCE_MODE_MAX) || (b0[1] && !backupOk);
   wire        keyBad   = (b0[6:1] != 6'h00) || (b0[7] && !chainOk);
   wire        carry    = b0[0];
   wire        backup   = b0[1];
   wire [7:0]  wrByte   = b1;
   wire [15:0] decSw    = (cla != `CCE_CLA) ? `CCE_SW_CLA :
                          isSel   ? ((lenReg != `CCE_LC_SELECT) ? `CCE_SW_LEN :
                                     p12Bad ? `CCE_SW_P1P2 :
                                     (b0 != `CCE_CARD_TYPE) ? `CCE_SW_DATA : `CCE_SW_OK) :
                          isRd    ? ((p1 != 8'h00) ? `CCE_SW_P1P2 : `CCE_SW_OK) :
                          isWr    ? ((lenReg != `CCE_LC_WRITE) ? `CCE_SW_LEN :
                                     (p1 != 8'h00) ? `CCE_SW_P1P2 :
                                     modeBad ? `CCE_SW_DATA : `CCE_SW_OK) :
                          isCode  ? ((lenReg != `CCE_LC_CODE) ? `CCE_SW_LEN :
                                     p12Bad ? `CCE_SW_P1P2 : `CCE_SW_OK) :
                          isAuth  ? ((lenReg != `CCE_LC_AUTH) ? `CCE_SW_LEN :
                                     p12Bad ? `CCE_SW_P1P2 :
                                     keyBad ? `CCE_SW_DATA : `CCE_SW_OK) :
                          isFetch ? ((lenReg != `CCE_LC_FETCH) ? `CCE_SW_LEN :
                                     p12Bad ? `CCE_SW_P1P2 :
                                     !resHeld ? `CCE_SW_NORES : `CCE_SW_OK) : `CCE_SW_INS;
   wire        decOk    = (decSw == `CCE_SW_OK);
   wire        decStop  = !decOk || (isRd && lenReg == 8'h00);
   cce_state_t decNext;
   assign decNext = decStop ? ST_DONE :
                    isSel   ? ST_PWROFF :
                    isAuth  ? ST_KEY :
                    isFetch ? ST_FETCH : ST_SEEKRST;
   // ----------------------------------------
   // card operation per state
   // ----------------------------------------
   wire [5:0]  idxCode  = 6'(bitCnt + 6'h08);
   wire [5:0]  idxChal  = 6'(bitCnt + 6'h10);
   wire        wrBit    = wrByte[bitCnt[2:0]];
   wire [7:0]  keyPulse = {6'h00, b0[7], b0[0]} + 8'h01;
   wire        cardStep = (st == ST_PWRON) || (st == ST_SEEKRST) || (st == ST_SEEK) || (st == ST_RDBIT) ||
                          (st == ST_WRBIT) || (st == ST_CARRY) || (st == ST_SCAN) || (st == ST_SKIP) ||
                          (st == ST_PROG) || (st == ST_SEND) || (st == ST_KEY) || (st == ST_CHAL) ||
                          (st == ST_ACLK) || (st == ST_ARD) || (st == ST_AEND);
   cce_op_t    opNow;
   assign opNow = (st == ST_PWRON)   ? cce_op_t'{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h01} :
                  (st == ST_SEEKRST) ? cce_op_t'{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00} :
                  (st == ST_SEEK)    ? cce_op_t'{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h08} :
                  (st == ST_WRBIT)   ? cce_op_t'{1'b0, backup & ~wrBit, ~wrBit, 1'b0, ~wrBit, 8'h01} :
                  (st == ST_CARRY)   ? cce_op_t'{1'b0, backup, 1'b1, 1'b1, 1'b1, 8'h01} :
                  (st == ST_SCAN)    ? cce_op_t'{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00} :
                  (st == ST_PROG)    ? cce_op_t'{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 8'h01} :
                  (st == ST_SEND)    ? cce_op_t'{1'b0, 1'b0, 1'b1, dataVec[idxCode], 1'b0, 8'h01} :
                  (st == ST_KEY)     ? cce_op_t'{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, keyPulse} :
                  (st == ST_CHAL)    ? cce_op_t'{1'b0, 1'b0, 1'b1, dataVec[idxChal], 1'b0, 8'h01} :
                  (st == ST_ACLK)    ? cce_op_t'{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, b1} :
                  (st == ST_ARD)     ? cce_op_t'{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00} :
                  (st == ST_AEND)    ? cce_op_t'{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00} :
                                       cce_op_t'{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h01};
   wire        stepDone = waitOp && phyDone;
   // ----------------------------------------
   // command sequencer
   // ----------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         st        <= ST_IDLE;
         afterSeek <= ST_IDLE;
         retState  <= ST_IDLE;
         busy      <= 1'b0;
         sw        <= `CCE_SW_OK;
         waitOp    <= 1'b0;
         start     <= 1'b0;
         bitCnt    <= 6'h00;
         byteCnt   <= 8'h00;
         seekAddr  <= 8'h00;
         pwrCnt    <= 32'h00000000;
         cardPower <= 1'b0;
         dataValid <= 1'b0;
         rdata     <= 8'h00;
         res       <= 16'h0000;
         resHeld   <= 1'b0;
      end else begin
         start <= 1'b0;
         if (popReq) dataValid <= 1'b0;
         if (cardStep && !waitOp && !start) begin
            start  <= 1'b1;
            waitOp <= 1'b1;
         end
         if (stepDone) waitOp <= 1'b0;
         case (st)
            ST_IDLE: if (goReq) begin
               busy <= 1'b1;
               st   <= ST_DECODE;
            end
            ST_DECODE: begin
               st        <= decNext;
               sw        <= decSw;
               bitCnt    <= 6'h00;
               byteCnt   <= isFetch ? 8'h02 : lenReg;
               seekAddr  <= isCode ? b0 : p2;
               afterSeek <= isRd ? ST_RDBIT : isWr ? ST_WRBIT : ST_SCAN;
               retState  <= isRd ? ST_RDBIT : ST_FETCH;
               if (!decStop && isSel) begin
                  cardPower <= 1'b0;
                  pwrCnt    <= 32'h00000000;
               end
               if (!decStop && isAuth) resHeld <= 1'b0;
            end
            ST_PWROFF: if (pwrCnt == 32'(POWER_OFF_CYC - 1)) begin
               cardPower <= 1'b1;
               st        <= ST_PWRON;
            end else begin
               pwrCnt <= pwrCnt + 32'h00000001;
            end
            ST_PWRON: if (stepDone) begin
               resHeld <= 1'b0;
               sw      <= `CCE_SW_OK;
               st      <= ST_DONE;
            end
            ST_SEEKRST: if (stepDone) begin
               st <= (seekAddr == 8'h00) ? afterSeek : ST_SEEK;
            end
            ST_SEEK: if (stepDone) begin
               seekAddr <= seekAddr - 8'h01;
               if (seekAddr == 8'h01) st <= afterSeek;
            end
            ST_RDBIT: if (stepDone) begin
               rdata[bitCnt[2:0]] <= phyBit;
               bitCnt             <= (bitCnt == 6'h07) ? 6'h00 : bitCnt + 6'h01;
               if (bitCnt == 6'h07) begin
                  dataValid <= 1'b1;
                  byteCnt   <= byteCnt - 8'h01;
                  st        <= ST_PUSH;
               end
            end
            ST_PUSH: if (!dataValid) begin
               st <= (byteCnt == 8'h00) ? ST_DONE : retState;
            end
            ST_FETCH: begin
               rdata     <= (byteCnt == 8'h02) ? res[7:0] : res[15:8];
               dataValid <= 1'b1;
               byteCnt   <= byteCnt - 8'h01;
               st        <= ST_PUSH;
            end
            ST_WRBIT: if (stepDone) begin
               bitCnt <= bitCnt + 6'h01;
               if (bitCnt == 6'h07) st <= carry ? ST_CARRY : ST_DONE;
            end
            ST_CARRY: if (stepDone) st <= ST_DONE;
            ST_SCAN: if (stepDone) begin
               if (phyBit) begin
                  st <= ST_PROG;
               end else if (bitCnt == 6'h07) begin
                  sw <= `CCE_SW_LOCKED;
                  st <= ST_DONE;
               end else begin
                  st <= ST_SKIP;
               end
            end
            ST_SKIP: if (stepDone) begin
               bitCnt <= bitCnt + 6'h01;
               st     <= ST_SCAN;
            end
            ST_PROG: if (stepDone) begin
               bitCnt <= 6'h00;
               st     <= ST_SEND;
            end
            ST_SEND: if (stepDone) begin
               bitCnt <= bitCnt + 6'h01;
               if (bitCnt == 6'h17) st <= ST_DONE;
            end
            ST_KEY: if (stepDone) begin
               bitCnt <= 6'h00;
               st     <= ST_CHAL;
            end
            ST_CHAL: if (stepDone) begin
               bitCnt <= (bitCnt == 6'h2F) ? 6'h00 : bitCnt + 6'h01;
               if (bitCnt == 6'h2F) st <= ST_ACLK;
            end
            ST_ACLK: if (stepDone) st <= ST_ARD;
            ST_ARD: if (stepDone) begin
               res[bitCnt[3:0]] <= phyBit;
               bitCnt           <= bitCnt + 6'h01;
               st               <= (bitCnt == 6'h0F) ? ST_AEND : ST_ACLK;
            end
            ST_AEND: if (stepDone) begin
               resHeld <= 1'b1;
               sw      <= `CCE_SW_AUTH_OK;
               st      <= ST_DONE;
            end
            ST_DONE: begin
               busy <= 1'b0;
               st   <= ST_IDLE;
            end
            default: st <= ST_IDLE;
         endcase
      end
   end
   // ----------------------------------------
   // card line driver
   // ----------------------------------------
   cce_sync u_sync (
      .clock (clock),
      .rstn  (rstn),
      .din   (cardIoIn),
      .dout  (ioSync)
   );
   cce_card_phy u_phy (
      .clock   (clock),
      .rstn    (rstn),
      .start   (start),
      .op      (opNow),
      .ioIn    (ioSync),
      .done    (phyDone),
      .bitIn   (phyBit),
      .cardClk (cardClk),
      .cardRst (cardRst),
      .cardAux (cardAux),
      .ioOut   (cardIoOut),
      .ioOe    (cardIoOe)
   );
endmodule
`default_nettype wire

// [cce_engine_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module cce_engine_properties (
   input wire logic        clock,
   input wire logic        rstn,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        cardPower,
   input wire logic        cardClk,
   input wire logic        cardRst,
   input wire logic        cardAux,
   input wire logic        cardIoOe
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);
   a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack held");
   a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
   a_dat_quiet: assert property (!ack_o |-> dat_o == 32'h0) else $error("data off ack");
   a_power_gap: assert property ($fell(cardPower) |=> !cardPower [*8]) else $error("short power off");
   a_power_reset: assert property ($rose(cardPower) |-> ##[0:200] cardRst) else $error("no reset");
   a_idle_card: assert property (!cardPower |-> !cardClk && !cardIoOe) else $error("card driven");
   a_clk_width: assert property ($rose(cardClk) |-> cardClk [*8]) else $error("short clock");
   a_aux_power: assert property (cardAux |-> cardPower) else $error("aux unpowered");
   cover property ($rose(cardPower));
   cover property ($rose(cardAux));
   cover property (ack_o && !we_i);
endmodule
bind cce_engine cce_engine_properties chk (.clock(clock), .rstn(rstn), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
   .dat_o(dat_o), .ack_o(ack_o), .cardPower(cardPower), .cardClk(cardClk), .cardRst(cardRst), .cardAux(cardAux),
   .cardIoOe(cardIoOe));
`default_nettype wire

// [cce_engine_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; $display("BAD %s %h %h", n, e, g); end end
module cce_engine_tb;
   logic        clock = 1'b0;
   logic        rstn = 1'b0;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] dat = 32'h0;
   logic [31:0] rdat, got;
   logic        ack, pwr, cclk, crst, caux, ioIn, ioOut, ioOe;
   logic [7:0]  prog;
   logic [7:0]  kc [5] = '{8'h02, 8'h00, 8'h01, 8'h80, 8'h81};
   int          error_cnt = 0;
   int          comparisons = 0;
   always #50 clock = ~clock;
   cce_engine #(.POWER_OFF_CYC(20)) dut (.clock(clock), .rstn(rstn), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .dat_i(dat), .sel_i(4'hF), .dat_o(rdat), .ack_o(ack), .cardPower(pwr), .cardClk(cclk),
      .cardRst(crst), .cardAux(caux), .cardIoIn(ioIn), .cardIoOut(ioOut), .cardIoOe(ioOe));
   cce_card_model card (.cardClk(cclk), .cardRst(crst), .ioOut(ioOut), .ioOe(ioOe), .ioIn(ioIn), .progBits(prog));
   task summarize;
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task timeout;
      error_cnt++;
      summarize;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
      do @(posedge clock); while (ack !== 1'b1 && ++n < 200);
      got = rdat;
      if (ack !== 1'b1) timeout;
      {cyc, stb} <= 2'b00;
      @(posedge clock);
   endtask
   // poll until a response byte waits or the command ends
   task automatic waitr;
      int n;
      n = 0;
      do bus(1'b0, 8'h04, 32'h0); while (got[0] === 1'b1 && got[1] !== 1'b1 && ++n < 20000);
      if (n >= 20000) timeout;
   endtask
   task automatic cmd(input logic [31:0] h, input logic [7:0] l, input logic [31:0] d0, input logic [31:0] d1);
      bus(1'b1, 8'h08, h);
      bus(1'b1, 8'h0C, {24'h0, l});
      bus(1'b1, 8'h10, d0);
      bus(1'b1, 8'h14, d1);
      bus(1'b1, 8'h00, 32'h1);
      waitr;
   endtask
   initial begin
      repeat (20) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      bus(1'b0, 8'h1C, 32'h0);
      `CHK("cfg", 32'h0, got)
      bus(1'b0, 8'h40, 32'h0);
      `CHK("unmapped", 32'h0, got)
      cmd(32'hFFA40000, 8'h01, 32'h06, 32'h0);
      `CHK("bad type", 16'h6A80, got[31:16])
      cmd(32'hFFA40000, 8'h01, 32'h07, 32'h0);
      `CHK("select", 16'h9000, got[31:16])
      cmd(32'hFFB00000, 8'h01, 32'h0, 32'h0);
      bus(1'b0, 8'h18, 32'h0);
      `CHK("read", 8'hC3, got[7:0])
      waitr;
      `CHK("read sw", 16'h9000, got[31:16])
      bus(1'b1, 8'h1C, 32'h1);
      for (int m = 0; m < 5; m++) begin
         cmd(32'hFFD00001, 8'h02, {16'h0, 8'hFE, 8'(m)}, 32'h0);
         `CHK("write", (m < 4) ? 16'h9000 : 16'h6A80, got[31:16])
         if (m == 0) `CHK("wire", 8'hFE, prog)
         if (m == 1) `CHK("carry", 8'hFF, prog)
      end
      cmd(32'hFFD00001, 8'h03, 32'hFE00, 32'h0);
      `CHK("write len", 16'h6700, got[31:16])
      bus(1'b1, 8'h1C, 32'h0);
      cmd(32'hFFD00001, 8'h02, 32'hFE02, 32'h0);
      `CHK("no backup", 16'h6A80, got[31:16])
      cmd(32'hFF200000, 8'h04, 32'h56341209, 32'h0);
      `CHK("code", 16'h9000, got[31:16])
      `CHK("no erase", 8'h56, prog)
      cmd(32'hFFC00000, 8'h02, 32'h0, 32'h0);
      `CHK("no result", 16'h6985, got[31:16])
      bus(1'b1, 8'h1C, 32'h3);
      for (int k = 0; k < 5; k++) begin
         cmd(32'hFF840000, 8'h08, {16'h2211, 8'h03, kc[k]}, 32'h66554433);
         `CHK("auth", (k > 0) ? 16'h6102 : 16'h6A80, got[31:16])
      end
      cmd(32'hFFC00000, 8'h02, 32'h0, 32'h0);
      bus(1'b0, 8'h18, 32'h0);
      `CHK("res lo", 8'h92, got[7:0])
      waitr;
      bus(1'b0, 8'h18, 32'h0);
      `CHK("res hi", 8'hF4, got[7:0])
      waitr;
      `CHK("fetch sw", 16'h9000, got[31:16])
      summarize;
   end
endmodule
`default_nettype wire

// [cce_map.svh]
// Notes on behaviour
// - select type 07h: power cycle, reset, 90 00
// - read length bytes from address, then status
// - write D0h, length 02h: address, mode, data
// - written bytes leave least significant bit first
// - mode 00 plain, 01 carry, 02/03 backup
// - carry: write byte, then erase lower stage
// - backup modes raise backup line during write
// - never erase target byte before programming
// - present code 20h, length 04h, address, code
// - program one counter bit, then send code
// - no counter erase after code presentation
// - authenticate 84h, length 08h: key, count, challenge
// - key 00/01 plain, 80/81 chained
// - given pulse count per result bit
// - key, challenge, clock, read 16, reset
// - authenticate success answers 61 02
// - fetch C0h returns result LSB first, 90 00
`ifndef CCE_MAP_SVH
`define CCE_MAP_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define CCE_ADR_CTRL    8'h00
`define CCE_ADR_STATUS  8'h04
`define CCE_ADR_HDR     8'h08
`define CCE_ADR_LEN     8'h0C
`define CCE_ADR_DATA0   8'h10
`define CCE_ADR_DATA1   8'h14
`define CCE_ADR_RDATA   8'h18
`define CCE_ADR_CFG     8'h1C
`define CCE_CFG_RST     2'h0
// ----------------------------------------
// command codes
// ----------------------------------------
`define CCE_CLA         8'hFF
`define CCE_INS_SELECT  8'hA4
`define CCE_INS_READ    8'hB0
`define CCE_INS_WRITE   8'hD0
`define CCE_INS_CODE    8'h20
`define CCE_INS_AUTH    8'h84
`define CCE_INS_FETCH   8'hC0
`define CCE_LC_SELECT   8'h01
`define CCE_LC_WRITE    8'h02
`define CCE_LC_CODE     8'h04
`define CCE_LC_AUTH     8'h08
`define CCE_LC_FETCH    8'h02
`define CCE_CARD_TYPE   8'h07
`define CCE_MODE_MAX    8'h03
// ----------------------------------------
// status words
// ----------------------------------------
`define CCE_SW_OK       16'h9000
`define CCE_SW_AUTH_OK  16'h6102
`define CCE_SW_LEN      16'h6700
`define CCE_SW_P1P2     16'h6A86
`define CCE_SW_DATA     16'h6A80
`define CCE_SW_INS      16'h6D00
`define CCE_SW_CLA      16'h6E00
`define CCE_SW_NORES    16'h6985
`define CCE_SW_LOCKED   16'h6983
// ----------------------------------------
// timing
// ----------------------------------------
`define CCE_CLK_MHZ     10
`define CCE_HALF_NS     5000
`define CCE_HALF_CYC    16'((`CCE_HALF_NS * `CCE_CLK_MHZ + 999) / 1000)
`define CCE_PROG_NS     100000
`define CCE_PROG_CYC    16'((`CCE_PROG_NS * `CCE_CLK_MHZ + 999) / 1000)
`define CCE_PWROFF_NS   1000000
`define CCE_PWROFF_CYC  ((`CCE_PWROFF_NS * `CCE_CLK_MHZ + 999) / 1000)
`endif

// [cce_pkg.sv]
package cce_pkg;
   typedef struct packed {
      logic       rst;
      logic       aux;
      logic       ioOe;
      logic       ioOut;
      logic       longHigh;
      logic [7:0] pulses;
   } cce_op_t;
   typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_HIGH, PH_LOW} cce_phase_t;
   typedef enum logic [4:0] {
      ST_IDLE, ST_DECODE, ST_PWROFF, ST_PWRON, ST_SEEKRST, ST_SEEK, ST_RDBIT, ST_PUSH,
      ST_WRBIT, ST_CARRY, ST_SCAN, ST_SKIP, ST_PROG, ST_SEND, ST_KEY, ST_CHAL,
      ST_ACLK, ST_ARD, ST_AEND, ST_FETCH, ST_DONE
   } cce_state_t;
endpackage

// [cce_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module cce_sync (
   input  wire logic clock,
   input  wire logic rstn,
   input  wire logic din,
   output logic      dout
);
   logic s1;
   logic s2;
   logic s3;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s1   <= 1'b0;
         s2   <= 1'b0;
         s3   <= 1'b0;
         dout <= 1'b0;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            dout <= s3;
         end
      end
   end
endmodule
`default_nettype wire
